// ===== design/mci_measure_regs.vh
// Behaviour
// - config bit picks thermistor or general input
// - pin result is raw signed 16-bit counts
// - pullup on only during thermistor pin conversion
// - reference: regulator for thermistor, bandgap otherwise
// - pin full scale is five thirds reference
// - raw current result is 24-bit, programmable rate
// - four raw intervals selected by config bits
// - low-power mode stretches raw intervals sixteen-fold
// - integration result every 250ms or 4s
// - 48-bit charge plus 32-bit seconds count
// - host command clears charge and time together
// - sleep freezes charge and time
// - die temperature is a loop slot, readable
// - die overtemp threshold turns FETs off, shutdown
// - offset and gain trim on cell, stack, die temperature and integrated current
// - trim offsets and gains stay host-writable
// - per-protection enable, three recovery policies
// - current faults from comparators, others from logic
// - FET drivers series/parallel, manual PWM
// - enabled bus timeout resets serial logic
`ifndef MCI_MEASURE_REGS_VH
`define MCI_MEASURE_REGS_VH

`define MCI_CLK_MHZ      50
`define MCI_RAW0_NS      366000
`define MCI_RAW1_NS      732000
`define MCI_RAW2_NS      1460000
`define MCI_RAW3_NS      2930000
`define MCI_LP_SHIFT     4
`define MCI_INT_MS       250
`define MCI_INT_LP_S     4
`define MCI_SEC_S        1
`define MCI_TO_MS        25
`define MCI_PWM_DIV      50

`define MCI_A_CFG        8'h00
`define MCI_A_PROTEN     8'h04
`define MCI_A_OTTHR      8'h08
`define MCI_A_CMD        8'h0c
`define MCI_A_PWM        8'h10
`define MCI_A_STATUS     8'h14
`define MCI_A_PIN        8'h18
`define MCI_A_TEMP       8'h1c
`define MCI_A_CELL       8'h20
`define MCI_A_STACK      8'h24
`define MCI_A_RAWCUR     8'h28
`define MCI_A_INTCUR     8'h2c
`define MCI_A_CHGLO      8'h30
`define MCI_A_CHGHI      8'h34
`define MCI_A_TIME       8'h38
`define MCI_A_TRIM       2'h1

`define MCI_CFG_GEN      0
`define MCI_CFG_RAWLO    1
`define MCI_CFG_LP       3
`define MCI_CFG_PAR      4
`define MCI_CFG_POLLO    5
`define MCI_CFG_TOEN     7
`define MCI_CFG_SHDN     8
`define MCI_CMD_CLRQ     0
`define MCI_CMD_RECOV    1

`define MCI_CFG_RST      9'h000
`define MCI_PROTEN_RST   5'h1f
`define MCI_OTTHR_RST    16'h0320
`define MCI_GAIN_RST     16'h4000
`define MCI_OFF_RST      16'h0000

`endif

// ===== design/mci_measure_core.v
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "mci_measure_regs.vh"

module mci_measure_core #(
  parameter [31:0] RAW_CYC0   = `MCI_RAW0_NS * `MCI_CLK_MHZ / 1000,
  parameter [31:0] RAW_CYC1   = RAW_CYC0 * 32'd2,      // exactly twice
  parameter [31:0] RAW_CYC2   = `MCI_RAW2_NS * `MCI_CLK_MHZ / 1000,
  parameter [31:0] RAW_CYC3   = `MCI_RAW3_NS * `MCI_CLK_MHZ / 1000,
  parameter [31:0] INT_CYC    = `MCI_INT_MS * `MCI_CLK_MHZ * 1000,
  parameter [31:0] INT_LP_CYC = INT_CYC << `MCI_LP_SHIFT, // exactly 16x
  parameter [31:0] SEC_CYC    = `MCI_SEC_S * `MCI_CLK_MHZ * 1000000,
  parameter [31:0] TO_CYC     = `MCI_TO_MS * `MCI_CLK_MHZ * 1000,
  parameter [7:0]  PWM_DIV    = `MCI_PWM_DIV,
  parameter        ACC_SHIFT  = 16
) (
  input  wire        clk,
  input  wire        srst,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  output reg         adcStart,
  output reg  [1:0]  adcChan,
  input  wire        adcDone,
  input  wire [15:0] adcData,
  output reg         mpPullupEn,
  output reg         refSelLdo,
  input  wire [23:0] rawFiltData,
  output reg         rawFiltStrobe,
  input  wire [15:0] intFiltData,
  output reg         intFiltStrobe,
  input  wire        sleepMode,
  input  wire        occCmp,
  input  wire        ocd1Cmp,
  input  wire        ocd2Cmp,
  input  wire        scdCmp,
  output reg         chgFetOn,
  output reg         dsgFetOn,
  output reg         shutdownReq,
  output reg         alertOut,
  input  wire        sclIn,
  output reg         busTimeoutRst
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CONV = 3'h2;
  localparam [2:0] ST_TRIM = 3'h4;

  function [15:0] trimApply;
    input [15:0] raw;
    input [15:0] gain;
    input [15:0] off;
    reg signed [31:0] prod;
    begin
      prod = $signed(raw) * $signed(gain);
      trimApply = prod[29:14] + off;
    end
  endfunction

  function trimHit;
    input [7:0] a;
    begin
      trimHit = (a[7:6] == `MCI_A_TRIM) && (a[5] == 1'b0) &&
                (a[1:0] == 2'h0);
    end
  endfunction

  function [31:0] rawPeriod;
    input [1:0] sel;
    input       lp;
    reg [31:0] b;
    begin
      case (sel)
        2'h0:    b = RAW_CYC0;
        2'h1:    b = RAW_CYC1;
        2'h2:    b = RAW_CYC2;
        default: b = RAW_CYC3;
      endcase
      rawPeriod = lp ? (b << `MCI_LP_SHIFT) : b;
    end
  endfunction

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  reg [8:0]  cfg_q;
  reg [4:0]  protEn_q;
  reg [15:0] otThr_q;
  reg [15:0] pwm_q;
  reg [4:0]  status_q;
  reg [4:0]  active_q;
  reg [15:0] trimGain_q [0:3];
  reg [15:0] trimOff_q  [0:3];
  reg [15:0] pinRes_q;
  reg [15:0] tempRes_q;
  reg [15:0] cellRes_q;
  reg [15:0] stackRes_q;
  reg [23:0] rawRes_q;
  reg [15:0] intRes_q;
  reg        intNew_q;
  reg [47:0] charge_q;
  reg [31:0] time_q;
  reg [31:0] secCnt_q;
  reg [31:0] rawCnt_q;
  reg [31:0] intCnt_q;
  reg [31:0] toCnt_q;
  reg [7:0]  pwmDiv_q;
  reg [7:0]  pwmCnt_q;
  reg [2:0]  state_q;
  reg [1:0]  slot_q;
  reg [15:0] conv_q;
  reg [4:0]  sync1_q;
  reg [4:0]  sync2_q;

  wire       genMode  = cfg_q[`MCI_CFG_GEN];
  wire [1:0] rawSel   = cfg_q[`MCI_CFG_RAWLO+1:`MCI_CFG_RAWLO];
  wire       lowPwr   = cfg_q[`MCI_CFG_LP];
  wire [1:0] policy   = cfg_q[`MCI_CFG_POLLO+1:`MCI_CFG_POLLO];
  wire       wrCmd    = regWr && (regAddr == `MCI_A_CMD);
  wire       clrQ     = wrCmd && regWdata[`MCI_CMD_CLRQ];
  wire       recover  = wrCmd && regWdata[`MCI_CMD_RECOV];
  wire       wrStat   = regWr && (regAddr == `MCI_A_STATUS);
  wire       autoRec  = (policy == 2'h0);
  wire       acting   = (policy == 2'h0) || (policy == 2'h1);
  wire       dieOt    = $signed(tempRes_q) >= $signed(otThr_q);
  wire [4:0] cond     = {dieOt, sync2_q[3:0]} & protEn_q;
  wire [31:0] rawLim  = rawPeriod(rawSel, lowPwr);
  wire [31:0] intLim  = lowPwr ? INT_LP_CYC : INT_CYC;
  wire [47:0] addend  = {{32{intRes_q[15]}}, intRes_q} << ACC_SHIFT;
  wire       chgBlk;
  wire       dsgBlk;
  wire       pwmOn    = pwmCnt_q < pwm_q[15:8];

  // ----------------------------------------------------------
  // register writes
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      cfg_q    <= `MCI_CFG_RST;
      protEn_q <= `MCI_PROTEN_RST;
      otThr_q  <= `MCI_OTTHR_RST;
      pwm_q    <= 16'h0000;
    end else if (regWr) begin
      case (regAddr)
        `MCI_A_CFG:    cfg_q    <= regWdata[8:0];
        `MCI_A_PROTEN: protEn_q <= regWdata[4:0];
        `MCI_A_OTTHR:  otThr_q  <= regWdata[15:0];
        `MCI_A_PWM:    pwm_q    <= regWdata[15:0];
        default: begin
        end
      endcase
    end
  end

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gTrim
      always @(posedge clk) begin
        if (srst) begin
          trimGain_q[k] <= `MCI_GAIN_RST;
          trimOff_q[k]  <= `MCI_OFF_RST;
        end else if (regWr && trimHit(regAddr) &&
                     (regAddr[4:3] == k)) begin
          if (regAddr[2])
            trimOff_q[k] <= regWdata[15:0];
          else
            trimGain_q[k] <= regWdata[15:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // read port
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      regRdata <= 32'h0000_0000;
    end else if (!regRd) begin
      regRdata <= 32'h0000_0000;
    end else if (trimHit(regAddr)) begin
      regRdata <= {16'h0000, regAddr[2] ? trimOff_q[regAddr[4:3]]
                                        : trimGain_q[regAddr[4:3]]};
    end else begin
      case (regAddr)
        `MCI_A_CFG:    regRdata <= {23'h0, cfg_q};
        `MCI_A_PROTEN: regRdata <= {27'h0, protEn_q};
        `MCI_A_OTTHR:  regRdata <= {16'h0, otThr_q};
        `MCI_A_PWM:    regRdata <= {16'h0, pwm_q};
        `MCI_A_STATUS: regRdata <= {11'h0, active_q, 11'h0, status_q};
        `MCI_A_PIN:    regRdata <= {16'h0, pinRes_q};
        `MCI_A_TEMP:   regRdata <= {16'h0, tempRes_q};
        `MCI_A_CELL:   regRdata <= {16'h0, cellRes_q};
        `MCI_A_STACK:  regRdata <= {16'h0, stackRes_q};
        `MCI_A_RAWCUR: regRdata <= {8'h0, rawRes_q};
        `MCI_A_INTCUR: regRdata <= {16'h0, intRes_q};
        `MCI_A_CHGLO:  regRdata <= charge_q[31:0];
        `MCI_A_CHGHI:  regRdata <= {16'h0, charge_q[47:32]};
        `MCI_A_TIME:   regRdata <= time_q;
        default:       regRdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // voltage converter slot sequence
  // ----------------------------------------------------------
  // slots: 0 cell, 1 stack, 2 die temperature, 3 multipurpose pin
  always @(posedge clk) begin
    if (srst) begin
      state_q    <= ST_IDLE;
      slot_q     <= 2'h0;
      adcStart   <= 1'b0;
      adcChan    <= 2'h0;
      mpPullupEn <= 1'b0;
      refSelLdo  <= 1'b0;
      conv_q     <= 16'h0000;
      pinRes_q   <= 16'h0000;
      tempRes_q  <= 16'h0000;
      cellRes_q  <= 16'h0000;
      stackRes_q <= 16'h0000;
    end else begin
      adcStart <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          adcStart   <= 1'b1;
          adcChan    <= slot_q;
          // bias only while the pin itself is converted
          mpPullupEn <= (slot_q == 2'h3) && !genMode;
          refSelLdo  <= (slot_q == 2'h3) && !genMode;
          state_q    <= ST_CONV;
        end
        ST_CONV: begin
          if (adcDone) begin
            conv_q     <= adcData;
            mpPullupEn <= 1'b0;
            refSelLdo  <= 1'b0;
            state_q    <= ST_TRIM;
          end
        end
        ST_TRIM: begin
          case (slot_q)
            2'h0: cellRes_q  <= trimApply(conv_q, trimGain_q[0],
                                          trimOff_q[0]);
            2'h1: stackRes_q <= trimApply(conv_q, trimGain_q[1],
                                          trimOff_q[1]);
            2'h2: tempRes_q  <= trimApply(conv_q, trimGain_q[2],
                                          trimOff_q[2]);
            // untrimmed counts; lsb is 5/3 of reference over 2^15
            default: pinRes_q <= conv_q;
          endcase
          slot_q  <= slot_q + 2'h1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // current filters
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      rawCnt_q      <= 32'h0000_0000;
      rawFiltStrobe <= 1'b0;
      rawRes_q      <= 24'h00_0000;
    end else if (rawCnt_q >= rawLim - 32'h1) begin
      rawCnt_q      <= 32'h0000_0000;
      rawFiltStrobe <= 1'b1;
      rawRes_q      <= rawFiltData;
    end else begin
      rawCnt_q      <= rawCnt_q + 32'h1;
      rawFiltStrobe <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      intCnt_q      <= 32'h0000_0000;
      intFiltStrobe <= 1'b0;
      intRes_q      <= 16'h0000;
      intNew_q      <= 1'b0;
    end else if (intCnt_q >= intLim - 32'h1) begin
      intCnt_q      <= 32'h0000_0000;
      intFiltStrobe <= 1'b1;
      intRes_q      <= trimApply(intFiltData, trimGain_q[3],
                                 trimOff_q[3]);
      intNew_q      <= 1'b1;
    end else begin
      intCnt_q      <= intCnt_q + 32'h1;
      intFiltStrobe <= 1'b0;
      intNew_q      <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // charge and time integration
  // ----------------------------------------------------------
  // a clear on the same cycle as a new sample wins: fresh start
  always @(posedge clk) begin
    if (srst) begin
      charge_q <= 48'h0000_0000_0000;
      time_q   <= 32'h0000_0000;
      secCnt_q <= 32'h0000_0000;
    end else if (clrQ) begin
      charge_q <= 48'h0000_0000_0000;
      time_q   <= 32'h0000_0000;
      secCnt_q <= 32'h0000_0000;
    end else if (!sleepMode) begin
      if (intNew_q)
        charge_q <= charge_q + addend;
      if (secCnt_q >= SEC_CYC - 32'h1) begin
        secCnt_q <= 32'h0000_0000;
        time_q   <= time_q + 32'h1;
      end else begin
        secCnt_q <= secCnt_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------
  // protections
  // ----------------------------------------------------------
  // comparator and bus clock inputs come from other domains
  always @(posedge clk) begin
    if (srst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {sclIn, scdCmp, ocd2Cmp, ocd1Cmp, occCmp};
      sync2_q <= sync1_q;
    end
  end

  // series: any fault opens both; parallel: each side alone, die overtemp opens both
  assign chgBlk = cfg_q[`MCI_CFG_PAR] ? (active_q[0] | active_q[4])
                                      : (|active_q);
  assign dsgBlk = cfg_q[`MCI_CFG_PAR] ? (|active_q[4:1])
                                      : (|active_q);

  always @(posedge clk) begin
    if (srst) begin
      active_q    <= 5'h00;
      status_q    <= 5'h00;
      alertOut    <= 1'b0;
      chgFetOn    <= 1'b0;
      dsgFetOn    <= 1'b0;
      shutdownReq <= 1'b0;
    end else begin
      // new condition wins over recovery or status clear
      active_q <= cond | (active_q & ~{5{autoRec | recover}});
      status_q <= cond | (status_q & ~(wrStat ? regWdata[4:0]
                                               : 5'h00));
      alertOut <= |status_q;
      chgFetOn <= !(acting && chgBlk) &&
                  (!pwm_q[0] || pwmOn);
      dsgFetOn <= !(acting && dsgBlk) &&
                  (!pwm_q[1] || pwmOn);
      shutdownReq <= acting && active_q[4] &&
                     cfg_q[`MCI_CFG_SHDN];
    end
  end

  // pwm runs on a slow enable so one duty step is visible at the fet
  always @(posedge clk) begin
    if (srst) begin
      pwmDiv_q <= 8'h00;
      pwmCnt_q <= 8'h00;
    end else if (pwmDiv_q >= PWM_DIV - 8'h01) begin
      pwmDiv_q <= 8'h00;
      pwmCnt_q <= pwmCnt_q + 8'h01;
    end else begin
      pwmDiv_q <= pwmDiv_q + 8'h01;
    end
  end

  // ----------------------------------------------------------
  // serial bus timeout
  // ----------------------------------------------------------
  // counter saturates so a stuck-low clock gives one pulse only
  always @(posedge clk) begin
    if (srst) begin
      toCnt_q       <= 32'h0000_0000;
      busTimeoutRst <= 1'b0;
    end else if (!cfg_q[`MCI_CFG_TOEN] || sync2_q[4]) begin
      toCnt_q       <= 32'h0000_0000;
      busTimeoutRst <= 1'b0;
    end else if (toCnt_q < TO_CYC) begin
      toCnt_q       <= toCnt_q + 32'h1;
      busTimeoutRst <= (toCnt_q == TO_CYC - 32'h1);
    end else begin
      busTimeoutRst <= 1'b0;
    end
  end

endmodule

// ===== tb/mci_measure_chk.sv
`timescale 1ns/1ps
module mci_measure_chk (
  input wire        clk,
  input wire        srst,
  input wire [7:0]  regAddr,
  input wire [31:0] regWdata,
  input wire        regWr,
  input wire        regRd,
  input wire [31:0] regRdata,
  input wire        adcStart,
  input wire [1:0]  adcChan,
  input wire        mpPullupEn,
  input wire        refSelLdo,
  input wire        rawFiltStrobe,
  input wire        intFiltStrobe,
  input wire        sclIn,
  input wire        busTimeoutRst
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reg       gen_q;
  reg       toEn_q;
  reg       seen_q;
  reg [1:0] last_q;
  // shadow of the mode bits, so checks need no register read
  always @(posedge clk) begin
    if (srst) begin
      gen_q  <= 1'b0;
      toEn_q <= 1'b0;
      seen_q <= 1'b0;
      last_q <= 2'h0;
    end else begin
      if (regWr && regAddr == 8'h00) begin
        gen_q  <= regWdata[0];
        toEn_q <= regWdata[7];
      end
      if (adcStart) begin
        seen_q <= 1'b1;
        last_q <= adcChan;
      end
    end
  end
  property p_pull;
    adcStart |-> mpPullupEn == (adcChan == 2'h3 && !$past(gen_q));
  endproperty
  a_pull: assert property (p_pull)
    else $error("pullup wrong at start");
  property p_pullOff;
    adcChan != 2'h3 |-> !mpPullupEn;
  endproperty
  a_pullOff: assert property (p_pullOff)
    else $error("pullup on outside pin slot");
  property p_ref;
    adcStart && adcChan == 2'h3 |-> refSelLdo == !$past(gen_q);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference wrong for pin");
  property p_startGap;
    adcStart |=> !adcStart [*3];
  endproperty
  a_startGap: assert property (p_startGap)
    else $error("conversion starts too close");
  property p_order;
    adcStart && seen_q |-> adcChan == last_q + 2'h1;
  endproperty
  a_order: assert property (p_order)
    else $error("slot order broken");
  property p_rdIdle;
    !$past(regRd) |-> regRdata == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");
  property p_rawGap;
    rawFiltStrobe |=> !rawFiltStrobe [*8];
  endproperty
  a_rawGap: assert property (p_rawGap)
    else $error("raw strobe too close");
  property p_intGap;
    intFiltStrobe |=> !intFiltStrobe [*8];
  endproperty
  a_intGap: assert property (p_intGap)
    else $error("integration strobe too close");
  property p_toCause;
    busTimeoutRst |-> toEn_q && !$past(sclIn, 4);
  endproperty
  a_toCause: assert property (p_toCause)
    else $error("bus reset without timeout");
  property p_toPulse;
    busTimeoutRst |=> !busTimeoutRst [*8];
  endproperty
  a_toPulse: assert property (p_toPulse)
    else $error("bus reset repeated");
  c_pin: cover property (adcStart && adcChan == 2'h3 && mpPullupEn);
  c_int: cover property (intFiltStrobe);
  c_to: cover property (busTimeoutRst);
endmodule

// ===== tb/mci_afe_model.sv
`timescale 1ns/1ps
module mci_afe_model (
  input  wire        clk,
  input  wire        adcStart,
  input  wire [1:0]  adcChan,
  input  wire [2:0]  lat,
  output reg         adcDone,
  output reg  [15:0] adcData
);
  reg [2:0] cnt_q;
  reg       busy_q;
  reg [1:0] ch_q;
  initial begin
    adcDone = 1'b0;
    adcData = 16'h0;
    busy_q  = 1'b0;
    cnt_q   = 3'h0;
    ch_q    = 2'h0;
  end
  // slot data 0x0023 + 0x0100 * slot; idle bus toggles so stale data fails
  always @(posedge clk) begin
    adcDone <= 1'b0;
    adcData <= ~adcData;
    if (adcStart) begin
      busy_q <= 1'b1;
      cnt_q  <= lat;
      ch_q   <= adcChan;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h0) begin
        busy_q  <= 1'b0;
        adcDone <= 1'b1;
        adcData <= {6'h0, ch_q, 8'h23};
      end
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "mci_measure_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  reg         clk, srst, regWr, regRd, sleepMode, sclIn, sclRun, sclLvl;
  reg  [7:0]  regAddr;
  reg  [31:0] regWdata, seed, expV;
  reg  [2:0]  lat;
  reg  [23:0] rawFiltData;
  reg  [15:0] intFiltData, v;
  reg  [3:0]  flt, f4;
  reg  [8:0]  c9;
  reg  [1:0]  d2, a2;
  reg  [16:0] tbl [0:5];
  reg  [47:0] acc;
  reg         rdSeen;
  reg  [31:0] expQ [$];
  integer     mismatches, checks, i, n, lastK;
  wire [31:0] regRdata;
  wire [15:0] adcData;
  wire [1:0]  adcChan;
  wire        adcStart, adcDone, mpPullupEn, refSelLdo, rawFiltStrobe;
  wire        intFiltStrobe, chgFetOn, dsgFetOn, shutdownReq, alertOut;
  wire        busTimeoutRst;
  mci_measure_core #(.RAW_CYC0(20), .RAW_CYC2(80), .RAW_CYC3(160),
    .INT_CYC(50), .TO_CYC(30)) dut (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .adcStart(adcStart), .adcChan(adcChan), .adcDone(adcDone),
    .adcData(adcData), .mpPullupEn(mpPullupEn), .refSelLdo(refSelLdo),
    .rawFiltData(rawFiltData), .rawFiltStrobe(rawFiltStrobe),
    .intFiltData(intFiltData), .intFiltStrobe(intFiltStrobe),
    .sleepMode(sleepMode), .occCmp(flt[0]), .ocd1Cmp(flt[1]),
    .ocd2Cmp(flt[2]), .scdCmp(flt[3]), .chgFetOn(chgFetOn),
    .dsgFetOn(dsgFetOn), .shutdownReq(shutdownReq), .alertOut(alertOut),
    .sclIn(sclIn), .busTimeoutRst(busTimeoutRst));
  mci_afe_model afe (.clk(clk), .adcStart(adcStart), .adcChan(adcChan),
    .lat(lat), .adcDone(adcDone), .adcData(adcData));
  // ----------------------------------------
  // clocks and monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // link clock, odd phase; stands at sclLvl outside frames
  initial begin
    #3;
    forever begin
      #80;
      sclIn = sclRun ? ~sclIn : sclLvl;
    end
  end
  always @(posedge clk) {lat, rawFiltData} <= 27'($random(seed));
  always @(posedge clk) begin
    if (rdSeen) begin
      expV = expQ.size() ? expQ.pop_front() : 32'hdead;
      `CHK(regRdata, expV)
    end
    rdSeen <= regRd;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task results;
    begin
      if (mismatches == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      expQ.push_back(e);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge clk);
  endtask
  // waits cnt strobes; lastK ends as the cycles between the last two
  task stb(input bit useInt, input integer cnt);
    integer j;
    begin
      for (j = 0; j < cnt; j++) begin
        lastK = 0;
        do begin
          @(posedge clk);
          #1;
          lastK++;
        end while ((useInt ? intFiltStrobe : rawFiltStrobe) !== 1'b1
                   && lastK < 4000);
        if (lastK >= 4000) begin
          mismatches++;
          results;
        end
      end
    end
  endtask
  task tally(input bit pwm, input integer len);
    begin
      n = 0;
      repeat (len) begin
        @(posedge clk);
        #1;
        n += ((pwm ? chgFetOn : busTimeoutRst) === 1'b1);
      end
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h2d507c25;
    {mismatches, checks, rdSeen, regWr, regRd, sleepMode} = 0;
    {regAddr, regWdata, intFiltData, flt, sclRun} = 0;
    {srst, sclIn, sclLvl} = 3'h7;
    // cfg, fault, fets during, fets after release
    tbl[0] = {9'h000, 4'h8, 2'b00, 2'b11};
    tbl[1] = {9'h010, 4'h1, 2'b01, 2'b11};
    tbl[2] = {9'h010, 4'h2, 2'b10, 2'b11};
    tbl[3] = {9'h010, 4'h4, 2'b10, 2'b11};
    tbl[4] = {9'h020, 4'h8, 2'b00, 2'b00};
    tbl[5] = {9'h040, 4'h1, 2'b11, 2'b11};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(`MCI_A_CFG, 32'h0);
    rd(`MCI_A_PROTEN, `MCI_PROTEN_RST);
    rd(`MCI_A_OTTHR, `MCI_OTTHR_RST);
    rd(8'h40, `MCI_GAIN_RST);
    rd(8'hfc, 32'h0);
    cyc(120);
    rd(`MCI_A_CELL, 32'h0023);
    rd(`MCI_A_TEMP, 32'h0223);
    rd(`MCI_A_PIN, 32'h0323);
    wr(8'h48, 32'h2000);
    wr(8'h4c, 32'h5);
    wr(`MCI_A_CFG, 32'h1);
    cyc(120);
    rd(`MCI_A_STACK, 32'h0096);
    rd(8'h48, 32'h2000);
    rd(`MCI_A_PIN, 32'h0323);
    for (i = 0; i < 8; i++) begin
      wr(`MCI_A_CFG, {28'h0, i[2], i[1:0], 1'b0});
      stb(0, 3);
      `CHK(lastK, (20 << i[1:0]) << (4 * i[2]))
    end
    wr(`MCI_A_CFG, 32'h0);
    stb(1, 3);
    `CHK(lastK, 50)
    wr(`MCI_A_CFG, 32'h8);
    stb(1, 3);
    `CHK(lastK, 50 << 4)
    wr(`MCI_A_CFG, 32'h0);
    for (i = 0; i < 2; i++) begin
      v = 16'($random(seed));
      intFiltData <= v;
      sleepMode <= 1'b1;
      wr(`MCI_A_CMD, 32'h1);
      cyc(300);
      rd(`MCI_A_CHGLO, 32'h0);
      rd(`MCI_A_CHGHI, 32'h0);
      rd(`MCI_A_TIME, 32'h0);
      stb(1, 1);
      cyc(5);
      sleepMode <= 1'b0;
      stb(1, 3);
      cyc(5);
      acc = ({{32{v[15]}}, v} * 48'd3) << 16;
      rd(`MCI_A_CHGLO, acc[31:0]);
      rd(`MCI_A_CHGHI, {16'h0, acc[47:32]});
    end
    for (i = 0; i < 6; i++) begin
      {c9, f4, d2, a2} = tbl[i];
      wr(`MCI_A_CFG, {23'h0, c9});
      wr(`MCI_A_STATUS, 32'h1f);
      cyc(8);
      flt <= f4;
      cyc(10);
      `CHK({chgFetOn, dsgFetOn}, d2)
      `CHK(alertOut, 1'b1)
      flt <= 4'h0;
      cyc(10);
      `CHK({chgFetOn, dsgFetOn}, a2)
      wr(`MCI_A_CMD, 32'h2);
      wr(`MCI_A_STATUS, 32'h1f);
      cyc(8);
      `CHK({chgFetOn, dsgFetOn}, 2'b11)
      `CHK(alertOut, 1'b0)
    end
    wr(`MCI_A_CFG, 32'h0);
    wr(`MCI_A_PWM, 32'h8001);
    tally(1, 256 * `MCI_PWM_DIV);
    `CHK(n, 128 * `MCI_PWM_DIV)
    `CHK(dsgFetOn, 1'b1)
    wr(`MCI_A_PWM, 32'h0);
    wr(`MCI_A_CFG, 32'h80);
    sclRun = 1'b1;
    tally(0, 200);
    `CHK(n, 0)
    sclRun = 1'b0;
    sclLvl = 1'b0;
    tally(0, 100);
    `CHK(n, 1)
    sclLvl = 1'b1;
    wr(`MCI_A_CFG, 32'h0);
    cyc(10);
    sclLvl = 1'b0;
    tally(0, 100);
    `CHK(n, 0)
    sclLvl = 1'b1;
    wr(`MCI_A_CFG, 32'h100);
    wr(`MCI_A_OTTHR, 32'h0200);
    cyc(150);
    `CHK({chgFetOn, dsgFetOn}, 2'b00)
    `CHK(shutdownReq, 1'b1)
    cyc(4);
    results;
  end
endmodule
bind mci_measure_core mci_measure_chk u_chk (
  .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .adcStart(adcStart), .adcChan(adcChan), .mpPullupEn(mpPullupEn),
  .refSelLdo(refSelLdo), .rawFiltStrobe(rawFiltStrobe),
  .intFiltStrobe(intFiltStrobe), .sclIn(sclIn),
  .busTimeoutRst(busTimeoutRst));
